// ---- hdl/cag_defs.svh ----
`ifndef CAG_DEFS_SVH
`define CAG_DEFS_SVH

// Call table placement and entry index field
`define CAG_TBL_BASE    16'h0040
`define CAG_TBL_END     16'h007F
`define CAG_TIDX_LSB    1
`define CAG_TIDX_MSB    5

// Fixed upper bits of short direct and SFR addresses, and the short direct SFR split
`define CAG_SHORT_TOP   7'h7F
`define CAG_SFR_TOP     8'hFF
`define CAG_SHORT_SFR   8'h20

// Register pair holding the accumulator and the base
`define CAG_PAIR_ACC    2'h0
`define CAG_PAIR_BASE   2'h3

// Reset values
`define CAG_RST_WORD    16'h0000
`define CAG_RST_BYTE    8'h00

`endif

// ---- hdl/cag_pkg.sv ----
`default_nettype none
`include "cag_defs.svh"

package cag_pkg;

    typedef enum logic [3:0] {
        CAG_M_DIRECT  = 4'h0,
        CAG_M_SHORT   = 4'h1,
        CAG_M_SFR     = 4'h2,
        CAG_M_REG_IND = 4'h3,
        CAG_M_BASED   = 4'h4,
        CAG_M_STACK   = 4'h5,
        CAG_M_TCALL   = 4'h6,
        CAG_M_REG_BR  = 4'h7,
        CAG_M_REL_BR  = 4'h8,
        CAG_M_IMM_BR  = 4'h9,
        CAG_M_REG     = 4'hA
    } cag_mode_t;

    typedef enum logic [2:0] {
        CAG_ST_IDLE = 3'h1,
        CAG_ST_LO   = 3'h2,
        CAG_ST_HI   = 3'h4
    } cag_state_t;

    typedef struct packed {
        cag_mode_t   mode;
        logic [15:0] imm16;
        logic [7:0]  imm8;
        logic [1:0]  pair_sel;
        logic [2:0]  byte_sel;
        logic [15:0] next_pc;
    } cag_req_t;

    typedef struct packed {
        logic        byte_wr;
        logic [2:0]  idx;
        logic [7:0]  data;
        logic        sp_wr;
        logic [15:0] sp;
    } cag_rwr_t;

    // Immediates at 00H..1FH land on the SFR half, the rest on the RAM half
    // bit eight select
    function automatic logic [15:0] short_ea(input logic [7:0] imm);
        short_ea = {`CAG_SHORT_TOP, (imm < `CAG_SHORT_SFR), imm};
    endfunction

    function automatic logic [15:0] tbl_entry(input logic [7:0] imm);
        tbl_entry = `CAG_TBL_BASE + {10'h000, imm[`CAG_TIDX_MSB:`CAG_TIDX_LSB], 1'b0};
    endfunction

endpackage

`default_nettype wire

// ---- hdl/cag_regfile.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cag_defs.svh"

module cag_regfile (
    input  wire logic              i_core_clk, // Core clock
    input  wire logic              i_rst_n,    // Sync reset, active low
    input  wire cag_pkg::cag_rwr_t i_wr,       // Byte register and stack writes
    input  wire logic [1:0]        i_pair_sel, // Pair for indirect use
    input  wire logic [2:0]        i_byte_sel, // Byte register select
    output logic [15:0]            o_pair,     // Selected pair
    output logic [15:0]            o_acc,      // Accumulator pair
    output logic [15:0]            o_base,     // Base pair
    output logic [15:0]            o_sp,       // Stack pointer
    output logic [7:0]             o_byte      // Selected byte register
);

    logic [7:0]  regs [8];
    logic [15:0] stack_pointer_reg;

    // Pair n is built from byte registers 2n+1 (high) and 2n (low)
    function automatic logic [15:0] pair_of(input logic [1:0] sel);
        pair_of = {regs[{sel, 1'b1}], regs[{sel, 1'b0}]};
    endfunction

    assign o_pair = pair_of(i_pair_sel);
    assign o_acc  = pair_of(`CAG_PAIR_ACC);
    assign o_base = pair_of(`CAG_PAIR_BASE);
    assign o_sp   = stack_pointer_reg;
    assign o_byte = regs[i_byte_sel];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 8; k++) begin
                regs[k] <= `CAG_RST_BYTE;
            end
        end else if (i_wr.byte_wr) begin
            regs[i_wr.idx] <= i_wr.data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stack_pointer_reg <= `CAG_RST_WORD;
        end else if (i_wr.sp_wr) begin
            stack_pointer_reg <= i_wr.sp;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/cag_ea_calc.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cag_defs.svh"

module cag_ea_calc (
    input  wire cag_pkg::cag_req_t i_req,    // Decoded request
    input  wire logic [15:0]       i_pair,   // Selected pair
    input  wire logic [15:0]       i_acc,    // Accumulator pair
    input  wire logic [15:0]       i_base,   // Base pair
    input  wire logic [15:0]       i_sp,     // Stack pointer
    output logic [15:0]            o_ea,     // Operand address
    output logic [15:0]            o_target  // Branch target
);

    wire [15:0] disp_ext = {{8{i_req.imm8[7]}}, i_req.imm8};
    wire [15:0] based    = i_base + {8'h00, i_req.imm8};
    wire [15:0] rel      = i_req.next_pc + disp_ext;

    always_comb begin
        o_ea = i_req.imm16;
        case (i_req.mode)
            cag_pkg::CAG_M_SHORT:   o_ea = cag_pkg::short_ea(i_req.imm8);
            cag_pkg::CAG_M_SFR:     o_ea = {`CAG_SFR_TOP, i_req.imm8};
            cag_pkg::CAG_M_REG_IND: o_ea = i_pair;
            cag_pkg::CAG_M_BASED:   o_ea = based;
            cag_pkg::CAG_M_STACK:   o_ea = i_sp;
            default:                o_ea = i_req.imm16;
        endcase
    end

    always_comb begin
        o_target = i_req.imm16;
        case (i_req.mode)
            cag_pkg::CAG_M_REG_BR: o_target = i_acc;
            cag_pkg::CAG_M_REL_BR: o_target = rel;
            default:               o_target = i_req.imm16;
        endcase
    end

endmodule

`default_nettype wire

// ---- hdl/cag_addr_gen.sv ----
// Overview of operation
// - Table call uses immediate bits 1..5 to pick a table entry for PC.
// - Call table lives at 40H..7FH; target may be anywhere in memory.
// - Branch via register loads accumulator pair into the program counter.
// - Direct mode uses the 16-bit immediate unchanged as operand address.
// - Short direct reaches 256-byte window FE20H..FF1FH with 8-bit immediate.
// - Short direct clears bit 8 for 20H..FFH, sets it for 00H..1FH.
// - SFR mode reaches FF00H..FFFFH through an 8-bit immediate.
// - A 3-bit code selects one of eight byte registers.
// - Bytes 0..7 and pairs 0..3 name the same storage as functions.
// - Register indirect uses selected pair contents as the address.
// - Based mode zero-extends displacement and adds base pair.
// - Based sum wraps modulo 65536; carry is dropped silently.
// - Stack operations address memory through the stack pointer.
// - Relative branch adds signed 8-bit displacement to next instruction.
// - Immediate call and branch load the 16-bit immediate into PC.
`timescale 1ns/1ns
`default_nettype none
`include "cag_defs.svh"

module cag_addr_gen (
    input  wire logic              i_core_clk,  // Core clock, 100 MHz
    input  wire logic              i_rst_n,     // Sync reset, active low
    input  wire logic              i_req_valid, // Request strobe
    input  wire cag_pkg::cag_req_t i_req,       // Mode and operand fields
    input  wire cag_pkg::cag_rwr_t i_reg_wr,    // Register file writes
    input  wire logic              i_mem_ack,   // Table byte returned
    input  wire logic [7:0]        i_mem_rdata, // Table byte
    output logic                   o_busy,      // Table fetch in flight
    output logic                   o_ea_valid,  // Operand address pulse
    output logic [15:0]            o_ea,        // Operand address
    output logic                   o_pc_load,   // Branch pulse
    output logic [15:0]            o_pc,        // Program counter value
    output logic                   o_mem_rd,    // Table read request
    output logic [15:0]            o_mem_addr,  // Table read address
    output logic                   o_reg_valid, // Byte register read pulse
    output logic [7:0]             o_reg_rdata  // Byte register data
);

    cag_pkg::cag_state_t state;
    cag_pkg::cag_state_t next_state;
    logic [7:0]          tbl_lo;

    wire [15:0] rf_pair;
    wire [15:0] rf_acc;
    wire [15:0] rf_base;
    wire [15:0] rf_sp;
    wire [7:0]  rf_byte;
    wire [15:0] calc_ea;
    wire [15:0] calc_target;

    cag_regfile u_regfile (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (i_reg_wr),
        .i_pair_sel (i_req.pair_sel),
        .i_byte_sel (i_req.byte_sel),
        .o_pair     (rf_pair),
        .o_acc      (rf_acc),
        .o_base     (rf_base),
        .o_sp       (rf_sp),
        .o_byte     (rf_byte)
    );

    cag_ea_calc u_ea_calc (
        .i_req    (i_req),
        .i_pair   (rf_pair),
        .i_acc    (rf_acc),
        .i_base   (rf_base),
        .i_sp     (rf_sp),
        .o_ea     (calc_ea),
        .o_target (calc_target)
    );

    // Requests are only taken while no table fetch is pending
    wire idle     = (state == cag_pkg::CAG_ST_IDLE);
    wire in_lo    = (state == cag_pkg::CAG_ST_LO);
    wire in_hi    = (state == cag_pkg::CAG_ST_HI);
    wire accept   = i_req_valid && idle;
    // Unknown mode codes fall into no group and raise no answer
    wire mode_ea  = (i_req.mode == cag_pkg::CAG_M_DIRECT)
                 || (i_req.mode == cag_pkg::CAG_M_SHORT)
                 || (i_req.mode == cag_pkg::CAG_M_SFR)
                 || (i_req.mode == cag_pkg::CAG_M_REG_IND)
                 || (i_req.mode == cag_pkg::CAG_M_BASED)
                 || (i_req.mode == cag_pkg::CAG_M_STACK);
    wire mode_br  = (i_req.mode == cag_pkg::CAG_M_REG_BR)
                 || (i_req.mode == cag_pkg::CAG_M_REL_BR)
                 || (i_req.mode == cag_pkg::CAG_M_IMM_BR);
    wire mode_tc  = (i_req.mode == cag_pkg::CAG_M_TCALL);
    wire mode_reg = (i_req.mode == cag_pkg::CAG_M_REG);
    // Table bytes arrive in order: low byte first, then high byte
    wire lo_done  = in_lo && i_mem_ack;
    wire hi_done  = in_hi && i_mem_ack;

    always_comb begin
        next_state = state;
        case (state)
            cag_pkg::CAG_ST_IDLE: begin
                if (accept && mode_tc) begin
                    next_state = cag_pkg::CAG_ST_LO;
                end
            end
            cag_pkg::CAG_ST_LO: begin
                if (i_mem_ack) begin
                    next_state = cag_pkg::CAG_ST_HI;
                end
            end
            cag_pkg::CAG_ST_HI: begin
                if (i_mem_ack) begin
                    next_state = cag_pkg::CAG_ST_IDLE;
                end
            end
            default: next_state = cag_pkg::CAG_ST_IDLE;
        endcase
    end

    // Busy comes from next_state so it rises together with the table read
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state  <= cag_pkg::CAG_ST_IDLE;
            o_busy <= 1'b0;
        end else begin
            state  <= next_state;
            o_busy <= (next_state != cag_pkg::CAG_ST_IDLE);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_ea_valid <= 1'b0;
            o_ea       <= `CAG_RST_WORD;
        end else begin
            o_ea_valid <= accept && mode_ea;
            if (accept && mode_ea) begin
                o_ea <= calc_ea;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_reg_valid <= 1'b0;
            o_reg_rdata <= `CAG_RST_BYTE;
        end else begin
            o_reg_valid <= accept && mode_reg;
            if (accept && mode_reg) begin
                o_reg_rdata <= rf_byte;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_mem_rd   <= 1'b0;
            o_mem_addr <= `CAG_RST_WORD;
            tbl_lo     <= `CAG_RST_BYTE;
        end else if (accept && mode_tc) begin
            o_mem_rd   <= 1'b1;
            o_mem_addr <= cag_pkg::tbl_entry(i_req.imm8);
        end else if (lo_done) begin
            tbl_lo     <= i_mem_rdata;
            o_mem_addr <= o_mem_addr + 16'h0001;
        end else if (hi_done) begin
            o_mem_rd   <= 1'b0;
        end
    end

    // A table result and a new branch never meet: requests wait while busy
    // program counter load
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_pc_load <= 1'b0;
            o_pc      <= `CAG_RST_WORD;
        end else begin
            o_pc_load <= (accept && mode_br) || hi_done;
            if (hi_done) begin
                o_pc <= {i_mem_rdata, tbl_lo};
            end else if (accept && mode_br) begin
                o_pc <= calc_target;
            end
        end
    end

    // Checks sample on the core clock and stay quiet during reset
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_take(cag_pkg::cag_mode_t m);
        accept && (i_req.mode == m);
    endsequence

    sequence s_lo_fetch;
        in_lo && i_mem_ack;
    endsequence

    sequence s_hi_fetch;
        in_hi && i_mem_ack;
    endsequence

    a_direct_ea_pass: assert property (
        s_take(cag_pkg::CAG_M_DIRECT) |=> o_ea_valid && o_ea == $past(i_req.imm16))
        else $error("direct address not passed through");

    a_short_ea_form: assert property (
        s_take(cag_pkg::CAG_M_SHORT) |=> o_ea_valid && o_ea[15:9] == 7'h7F
            && o_ea[7:0] == $past(i_req.imm8) && o_ea[8] == ($past(i_req.imm8) < 8'h20))
        else $error("short direct address wrong");

    a_sfr_ea_form: assert property (
        s_take(cag_pkg::CAG_M_SFR) |=> o_ea == {8'hFF, $past(i_req.imm8)})
        else $error("sfr address wrong");

    a_reg_ind_pair: assert property (
        s_take(cag_pkg::CAG_M_REG_IND) |=> o_ea == $past(rf_pair))
        else $error("indirect address not pair contents");

    a_based_sum_wrap: assert property (
        s_take(cag_pkg::CAG_M_BASED)
            |=> o_ea == 16'($past(rf_base) + {8'h00, $past(i_req.imm8)}))
        else $error("based address sum wrong");

    a_stack_ea_sp: assert property (
        s_take(cag_pkg::CAG_M_STACK) |=> o_ea_valid && o_ea == $past(rf_sp))
        else $error("stack address not stack pointer");

    a_reg_byte_read: assert property (
        s_take(cag_pkg::CAG_M_REG) |=> o_reg_valid && o_reg_rdata == $past(rf_byte))
        else $error("byte register read wrong");

    a_acc_branch_pc: assert property (
        s_take(cag_pkg::CAG_M_REG_BR) |=> o_pc_load && o_pc == $past(rf_acc))
        else $error("accumulator branch target wrong");

    a_rel_branch_pc: assert property (
        s_take(cag_pkg::CAG_M_REL_BR) |=> o_pc_load && o_pc
            == 16'($past(i_req.next_pc) + {{8{$past(i_req.imm8[7])}}, $past(i_req.imm8)}))
        else $error("relative branch target wrong");

    a_imm_branch_pc: assert property (
        s_take(cag_pkg::CAG_M_IMM_BR) |=> o_pc_load && o_pc == $past(i_req.imm16))
        else $error("immediate branch target wrong");

    a_tcall_entry_addr: assert property (
        s_take(cag_pkg::CAG_M_TCALL) |=> o_mem_rd && o_busy && o_mem_addr
            == 16'h0040 + {10'h000, $past(i_req.imm8[5:1]), 1'b0})
        else $error("table entry address wrong");

    a_tbl_in_range: assert property (
        o_mem_rd |-> o_mem_addr >= 16'h0040 && o_mem_addr <= 16'h007F)
        else $error("table read outside call table");

    a_tbl_hi_next: assert property (
        s_lo_fetch |=> o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001
            && tbl_lo == $past(i_mem_rdata))
        else $error("table high byte not at next address");

    a_tbl_pc_load: assert property (
        s_hi_fetch |=> o_pc_load && !o_mem_rd && !o_busy
            && o_pc == {$past(i_mem_rdata), $past(tbl_lo)})
        else $error("table entry not loaded into pc");

    a_short_window: assert property (
        s_take(cag_pkg::CAG_M_SHORT) ##0 (i_req.imm8 >= 8'h80 || i_req.imm8 < 8'h20)
            |=> o_ea >= 16'hFE80 && o_ea <= 16'hFF1F)
        else $error("short address outside window");

    a_sfr_page: assert property (
        s_take(cag_pkg::CAG_M_SFR) |=> o_ea_valid && o_ea >= 16'hFF00)
        else $error("sfr address outside register page");

    a_based_zero_ext: assert property (
        s_take(cag_pkg::CAG_M_BASED) ##0 (i_req.imm8[7] && rf_base < 16'hFF00)
            |=> o_ea_valid && o_ea > $past(rf_base))
        else $error("based displacement not zero extended");

    a_pair_acc_alias: assert property (
        s_take(cag_pkg::CAG_M_REG_IND) ##0 (i_req.pair_sel == 2'h0)
            |=> o_ea == $past(rf_acc))
        else $error("pair zero differs from accumulator pair");

    a_busy_refuse: assert property (
        !idle |=> !o_ea_valid && !o_reg_valid)
        else $error("request taken during table fetch");

    a_ea_hold: assert property (
        !o_ea_valid |-> $stable(o_ea))
        else $error("operand address changed without valid");

endmodule

`default_nettype wire

// ---- bench/cag_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module cag_mem_model (
    input  wire logic        i_core_clk,  // Core clock
    input  wire logic        i_rst_n,     // Sync reset, active low
    input  wire logic [3:0]  i_delay,     // Wait cycles before each ack
    input  wire logic        i_mem_rd,    // Table read request
    input  wire logic [15:0] i_mem_addr,  // Table read address
    output logic             o_mem_ack,   // Byte returned
    output logic [7:0]       o_mem_rdata  // Byte value
);
    logic [3:0] wait_cnt;
    logic [7:0] last_byte;
    logic [7:0] tbl_byte;

    // Table bytes follow the address so that every entry differs
    assign tbl_byte    = i_mem_addr[7:0] ^ 8'h5A;
    assign o_mem_ack   = i_mem_rd && (wait_cnt == i_delay);
    // Idle bus shows the inverse of the last byte, never a stale match
    assign o_mem_rdata = o_mem_ack ? tbl_byte : ~last_byte;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || !i_mem_rd || o_mem_ack) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
        if (!i_rst_n) begin
            last_byte <= 8'h00;
        end else if (o_mem_ack) begin
            last_byte <= tbl_byte;
        end
    end
endmodule

`default_nettype wire

// ---- bench/cpu_address_generation_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpu_address_generation_test;
    logic              clk;
    logic              rst_n;
    logic              req_valid;
    cag_pkg::cag_req_t req;
    cag_pkg::cag_rwr_t reg_wr;
    logic              mem_ack;
    logic [7:0]        mem_rdata;
    logic [3:0]        mem_delay;
    logic              busy;
    logic              ea_valid;
    logic              pc_load;
    logic              mem_rd;
    logic              reg_valid;
    logic [15:0]       ea;
    logic [15:0]       pc;
    logic [15:0]       mem_addr;
    logic [7:0]        reg_rdata;
    logic [15:0]       seen_addr[$];
    int                fail_count;
    int                compares;

    cag_addr_gen uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
        .i_reg_wr(reg_wr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy),
        .o_ea_valid(ea_valid), .o_ea(ea), .o_pc_load(pc_load), .o_pc(pc), .o_mem_rd(mem_rd),
        .o_mem_addr(mem_addr), .o_reg_valid(reg_valid), .o_reg_rdata(reg_rdata));

    cag_mem_model mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_delay(mem_delay),
        .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (mem_rd && mem_ack) begin
            seen_addr.push_back(mem_addr);
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] bval(input int i);
        bval = 8'hA0 | 8'(i);
    endfunction

    task automatic send(input cag_pkg::cag_mode_t m, input logic [15:0] a16,
                        input logic [7:0] a8, input logic [1:0] ps, input logic [2:0] bs,
                        input logic [15:0] npc);
        req_valid = 1'b1;
        req = '{mode: m, imm16: a16, imm8: a8, pair_sel: ps, byte_sel: bs, next_pc: npc};
        @(negedge clk);
    endtask

    task automatic idle();
        req_valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic op(input cag_pkg::cag_mode_t m, input logic [15:0] a16,
                      input logic [7:0] a8, input logic [1:0] ps, input logic [15:0] exp);
        send(m, a16, a8, ps, 3'h0, 16'h0000);
        check({15'h0000, ea_valid}, 16'h0001);
        check(ea, exp);
    endtask

    task automatic br(input cag_pkg::cag_mode_t m, input logic [15:0] a16,
                      input logic [7:0] a8, input logic [15:0] npc, input logic [15:0] exp);
        send(m, a16, a8, 2'h0, 3'h0, npc);
        check({15'h0000, pc_load}, 16'h0001);
        check(pc, exp);
    endtask

    task automatic wreg(input logic [2:0] idx, input logic [7:0] d);
        reg_wr = '{byte_wr: 1'b1, idx: idx, data: d, sp_wr: 1'b0, sp: 16'h0000};
        @(negedge clk);
    endtask

    task automatic t_reset();
        check({11'h000, busy, ea_valid, pc_load, mem_rd, reg_valid}, 16'h0000);
        check(ea | pc, 16'h0000);
        send(cag_pkg::CAG_M_REG, 16'h0000, 8'h00, 2'h0, 3'h1, 16'h0000);
        check({8'h00, reg_rdata}, 16'h0000);
        idle();
    endtask

    task automatic t_operands();
        logic [7:0]  sh_in[5]  = '{8'h00, 8'h1F, 8'h20, 8'h80, 8'hFF}; // byte operands only
        logic [15:0] sh_exp[5] = '{16'hFF00, 16'hFF1F, 16'hFE20, 16'hFE80, 16'hFEFF};
        op(cag_pkg::CAG_M_DIRECT, 16'h1234, 8'h00, 2'h0, 16'h1234);
        op(cag_pkg::CAG_M_DIRECT, 16'hFFFF, 8'h00, 2'h0, 16'hFFFF);
        for (int i = 0; i < 5; i++) begin
            op(cag_pkg::CAG_M_SHORT, 16'h0000, sh_in[i], 2'h0, sh_exp[i]);
            op(cag_pkg::CAG_M_SFR, 16'h0000, sh_in[i], 2'h0, {8'hFF, sh_in[i]});
        end
        send(cag_pkg::cag_mode_t'(4'hB), 16'h0000, 8'h00, 2'h0, 3'h0, 16'h0000);
        check({13'h0000, ea_valid, pc_load, reg_valid}, 16'h0000);
        idle();
    endtask

    task automatic t_registers();
        for (int i = 0; i < 8; i++) begin
            wreg(3'(i), bval(i));
        end
        reg_wr = '0;
        for (int i = 0; i < 8; i++) begin
            send(cag_pkg::CAG_M_REG, 16'h0000, 8'h00, 2'h0, 3'(i), 16'h0000);
            check({7'h00, reg_valid, reg_rdata}, {8'h01, bval(i)});
        end
        for (int n = 0; n < 4; n++) begin
            op(cag_pkg::CAG_M_REG_IND, 16'h0000, 8'h00, 2'(n),
               {bval(2 * n + 1), bval(2 * n)});
        end
        br(cag_pkg::CAG_M_REG_BR, 16'h0000, 8'h00, 16'h0000, {bval(1), bval(0)});
        op(cag_pkg::CAG_M_BASED, 16'h0000, 8'hF0, 2'h0, 16'hA896);
        idle();
        wreg(3'h6, 8'hF0);
        wreg(3'h7, 8'hFF);
        reg_wr = '{byte_wr: 1'b0, idx: 3'h0, data: 8'h00, sp_wr: 1'b1, sp: 16'hFE90};
        @(negedge clk);
        reg_wr = '0;
        op(cag_pkg::CAG_M_BASED, 16'h0000, 8'hF0, 2'h0, 16'h00E0);
        op(cag_pkg::CAG_M_STACK, 16'h0000, 8'h00, 2'h0, 16'hFE90);
        idle();
    endtask

    task automatic t_branches();
        br(cag_pkg::CAG_M_REL_BR, 16'h0000, 8'h80, 16'h1000, 16'h0F80);
        br(cag_pkg::CAG_M_REL_BR, 16'h0000, 8'h7F, 16'h1000, 16'h107F);
        br(cag_pkg::CAG_M_REL_BR, 16'h0000, 8'hFF, 16'h0000, 16'hFFFF);
        br(cag_pkg::CAG_M_IMM_BR, 16'hABCD, 8'h00, 16'h0000, 16'hABCD);
        idle();
    endtask

    task automatic t_tcall(input logic [7:0] a8, input logic [3:0] dly,
                           input logic [15:0] lo, input logic [15:0] exp);
        seen_addr.delete();
        mem_delay = dly;
        send(cag_pkg::CAG_M_TCALL, 16'h0000, a8, 2'h0, 3'h0, 16'h0000);
        check({14'h0000, busy, mem_rd}, 16'h0003);
        // A request during the fetch must be ignored
        send(cag_pkg::CAG_M_DIRECT, 16'hDEAD, 8'h00, 2'h0, 3'h0, 16'h0000);
        idle();
        for (int k = 0; k < 40 && pc_load !== 1'b1; k++) begin
            check({15'h0000, ea_valid}, 16'h0000);
            @(negedge clk);
        end
        check({14'h0000, pc_load, busy}, 16'h0002);
        check(pc, exp);
        check(16'(seen_addr.size()), 16'h0002);
        check(seen_addr[0], lo);
        check(seen_addr[1], lo + 16'h0001);
        @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        reg_wr = '0;
        mem_delay = 4'h0;
        fail_count = 0;
        compares = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_operands();
        t_registers();
        t_branches();
        t_tcall(8'hFF, 4'h3, 16'h007E, 16'h2524);
        t_tcall(8'h00, 4'h0, 16'h0040, 16'h1B1A);
        t_tcall(8'h14, 4'h1, 16'h0054, 16'h0F0E);
        final_report();
    end

    // Whole run needs about a hundred cycles; this margin only cuts a hang
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
